// ### pfc_pkg.sv
package pfc_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_READ_ALT  = 8'hff;
  localparam logic [7:0] CMD_ID        = 8'h90;
  localparam logic [7:0] CMD_ERASE     = 8'h30;
  localparam logic [7:0] CMD_PROG      = 8'h10;
  localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 17'h00000;
  localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 17'h00001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO   = 17'h00000;
  localparam int ID_LINE_BIT  = 9;
  localparam int TOP_BIT      = 7;
  localparam int T_SETUP_NS   = 200;
  localparam int CLK_NS       = 100;
  localparam logic [3:0] PHASE_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [1:0] OP_READ   = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_HWID   = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_STRB  = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_DONE  = 5'b10000
  } pfc_state_t;
endpackage

// ### pfc_phase_if.sv
`timescale 1ns/100ps
interface pfc_phase_if;
  logic start;
  logic tick;
  modport ctl (output start, input tick);
  modport tmr (input start, output tick);
endinterface

// ### pfc_phase_timer.sv
`timescale 1ns/100ps
module pfc_phase_timer (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  pfc_phase_if.tmr  ph
);
  import pfc_pkg::*;
  logic [3:0] cnt;
  wire        at_end = (cnt == 4'h1);
  // Each strobe phase lasts PHASE_CYC clocks so device setup times hold
  always_ff @(posedge clk_sys) begin
    if (sys_rst || ph.start) begin
      cnt <= sys_rst ? CNT_ZERO : PHASE_CYC;
    end else if (cnt != CNT_ZERO) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign ph.tick = at_end;
endmodule

// ### pfc_host.sv
`timescale 1ns/100ps
// How it works
// - Hardware id: other addresses low, low Vpp
// - Write: select, strobe low, gate high
// - Write 00h or FFh for array reads
// - Program second write carries location, value
module pfc_host (
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire logic [1:0]                 req_op,
  input  wire logic [pfc_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [pfc_pkg::DATA_W-1:0] req_data,
  output logic                            rsp_valid,
  output logic      [pfc_pkg::DATA_W-1:0] rsp_data,
  output logic                            rsp_parity_ok,
  input  wire logic                       vpp_high_in,
  output logic                            vpp_high_en,
  output logic                            id_high_voltage,
  output logic      [pfc_pkg::ADDR_W-1:0] mem_addr,
  output logic                            chip_sel_n,
  output logic                            out_gate_n,
  output logic                            wr_strobe_n,
  input  wire logic [pfc_pkg::DATA_W-1:0] mem_dq_in,
  output logic      [pfc_pkg::DATA_W-1:0] mem_dq_out,
  output logic                            mem_dq_oe
);
  import pfc_pkg::*;
  pfc_phase_if ph ();
  pfc_phase_timer u_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ph      (ph)
  );
  pfc_state_t state;
  pfc_state_t next_state;
  logic [1:0]        op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic              vpp_s1;
  logic              vpp_s2;
  wire is_write = (op == OP_WRITE);
  wire take     = (state == ST_IDLE) && req_valid;
  // A write is refused if the synchronised Vpp is low when it is taken; the device would ignore it anyway
  wire refuse   = take && (req_op == OP_WRITE) && !vpp_s2;
  wire launch   = take && !refuse;
  // Pins follow the request being taken, so no pin carries the previous access's op
  wire [1:0]        next_op    = launch ? req_op : op;
  wire              next_write = (next_op == OP_WRITE);
  wire              next_hwid  = (next_op == OP_HWID);
  wire              next_busy  = next_state inside {ST_SETUP, ST_STRB, ST_HOLD};
  wire              id_drive   = next_hwid && next_busy;
  // Hardware id: only the id and byte-select lines may be high
  wire [ADDR_W-1:0] take_addr  = (req_op == OP_HWID) ? ADDR_W'(req_addr[0]) : req_addr;
  wire [ADDR_W-1:0] next_addr  = launch ? take_addr : addr;
  wire [DATA_W-1:0] next_wdata = launch ? req_data : wdata;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  next_state = launch ? ST_SETUP : ST_IDLE;
      ST_SETUP: next_state = ph.tick ? ST_STRB : ST_SETUP;
      ST_STRB:  next_state = ph.tick ? ST_HOLD : ST_STRB;
      ST_HOLD:  next_state = ph.tick ? ST_DONE : ST_HOLD;
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end
  assign ph.start  = launch || ((state != ST_IDLE) && (state != ST_DONE) && ph.tick);
  assign req_ready = (state == ST_IDLE);
  wire in_hold     = (state == ST_HOLD);
  // Pins are synchronised before use: they come from outside this clock
  always_ff @(posedge clk_sys) begin
    dq_s1  <= mem_dq_in;
    dq_s2  <= dq_s1;
    vpp_s1 <= vpp_high_in;
    vpp_s2 <= vpp_s1;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      op    <= OP_READ;
      addr  <= ADDR_ZERO;
      wdata <= CMD_READ;
    end else begin
      state <= next_state;
      if (launch) begin
        op    <= req_op;
        addr  <= take_addr;
        wdata <= req_data;
      end
    end
  end
  // Strobes: chip select low for the whole access; it may drop between accesses
  // without harming a running erase or program
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chip_sel_n      <= 1'b1;
      out_gate_n      <= 1'b1;
      wr_strobe_n     <= 1'b1;
      mem_dq_oe       <= 1'b0;
      mem_dq_out      <= CMD_READ;
      mem_addr        <= ADDR_ZERO;
      id_high_voltage <= 1'b0;
      vpp_high_en     <= 1'b0;
    end else begin
      chip_sel_n      <= !next_busy;
      // Output gate stays high during writes so there is no bus contention
      out_gate_n      <= next_write || (next_state != ST_STRB);
      // Address is stable before the falling strobe, data held past the rising one
      wr_strobe_n     <= !(next_write && (next_state == ST_STRB));
      mem_dq_oe       <= next_write && next_busy;
      mem_dq_out      <= next_wdata;
      mem_addr        <= next_addr;
      id_high_voltage <= id_drive;
      // Low Vpp in reset and during hardware id readout, high otherwise to keep commands live
      vpp_high_en     <= !id_drive;
    end
  end
  // Two sync stages delay the pin, so read data is taken at the end of hold; writes answer zero
  wire sample = in_hold && ph.tick && !is_write;
  wire parity = ^dq_s2;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid     <= 1'b0;
      rsp_data      <= CMD_READ;
      rsp_parity_ok <= 1'b0;
    end else begin
      rsp_valid <= (state == ST_DONE) || refuse;
      if (sample) begin
        rsp_data      <= dq_s2;
        rsp_parity_ok <= parity;
      end else if (refuse || (launch && req_op == OP_WRITE)) begin
        rsp_data      <= CMD_READ;
        rsp_parity_ok <= 1'b0;
      end
    end
  end
endmodule

// ### pfc_host_properties.sv
`timescale 1ns/100ps
module pfc_host_properties (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_parity_ok,
  input wire logic        vpp_high_in,
  input wire logic        id_high_voltage,
  input wire logic [16:0] mem_addr,
  input wire logic        chip_sel_n,
  input wire logic        out_gate_n,
  input wire logic        wr_strobe_n,
  input wire logic        mem_dq_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence strobe_pulse;
    !wr_strobe_n [*2] ##1 wr_strobe_n;
  endsequence
  chk_gate_sel: assert property (!out_gate_n |-> !chip_sel_n) else $error("gate");
  chk_no_contend: assert property (mem_dq_oe |-> out_gate_n) else $error("contend");
  chk_write_qual: assert property (!wr_strobe_n |-> !chip_sel_n && out_gate_n && mem_dq_oe) else $error("qual");
  chk_strobe_pulse: assert property ($fell(wr_strobe_n) |-> strobe_pulse) else $error("pulse");
  chk_addr_hold: assert property (!wr_strobe_n |-> $stable(mem_addr)) else $error("addr");
  chk_vpp_refuse: assert property (!vpp_high_in [*8] |-> wr_strobe_n) else $error("vpp");
  chk_id_addr: assert property (id_high_voltage |-> mem_addr[16:1] == 16'h0) else $error("id addr");
  chk_parity_flag: assert property (rsp_valid |-> rsp_parity_ok == ^rsp_data) else $error("parity");
endmodule
bind pfc_host pfc_host_properties i_chk (.clk_sys, .sys_rst, .rsp_valid, .rsp_data, .rsp_parity_ok,
  .vpp_high_in, .id_high_voltage, .mem_addr, .chip_sel_n, .out_gate_n, .wr_strobe_n, .mem_dq_oe);

// ### pfc_flash_model.sv
`timescale 1ns/100ps
module pfc_flash_model #(
  parameter logic [7:0] MFR = 8'h00,
  parameter logic [7:0] DEV = 8'h00
) (
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        vpp,
  input  wire logic        idv,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dout
);
  logic [7:0] mem [256] = '{default: 8'hff};
  logic [7:0] cmd = 8'h00;
  logic [7:0] pa;
  wire        idm = idv || cmd == 8'h80 || cmd == 8'h90;
  wire  [7:0] rd = idm ? (addr[0] ? DEV : MFR) : mem[addr[7:0]];
  wire        wok = !cs_n && oe_n && vpp;
  // Released bus shows the inverse so a stale sample cannot pass
  assign dout = (!cs_n && !oe_n) ? rd : ~rd;
  always @(negedge we_n) if (wok) pa = addr[7:0];
  always @(negedge vpp) cmd = 8'h00;
  always @(posedge we_n) if (wok) begin
    if (cmd == 8'h10 || cmd == 8'h50) begin
      mem[pa] = din;
      cmd = 8'h00;
    end else if (cmd == 8'h30) begin
      if (din == 8'h30) mem = '{default: 8'hff};
      cmd = 8'h00;
    end else if (din inside {8'h00, 8'hff, 8'h80, 8'h90, 8'h30, 8'h10, 8'h50}) begin
      cmd = din;
    end
  end
endmodule

// ### pfc_host_tb.sv
`timescale 1ns/100ps
module pfc_host_tb;
  import pfc_pkg::*;
  localparam logic [7:0] MFR = 8'h4c; // Arbitrary, odd parity
  localparam logic [7:0] DEV = 8'hc7; // Arbitrary, odd parity
  logic clk_sys = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, vpp_ok = 1'b1;
  logic [1:0] req_op = 2'h0;
  logic [16:0] req_addr = 17'h0;
  logic [7:0] req_data = 8'h0;
  logic [15:0] sd = 16'hbd77;
  int n_mismatch = 0, compares = 0, lat = 0;
  wire req_ready, rsp_valid, rsp_parity_ok, vpp_high_en, id_high_voltage, chip_sel_n, out_gate_n, wr_strobe_n, mem_dq_oe;
  wire [7:0] rsp_data, mem_dq_out, dq;
  wire [7:0] mem_dq_in = mem_dq_oe ? mem_dq_out : dq;
  wire [16:0] mem_addr;
  wire vpp_high_in = vpp_high_en && vpp_ok;
  pfc_host i_pfc_host (.clk_sys, .sys_rst, .req_valid, .req_ready, .req_op, .req_addr, .req_data, .rsp_valid,
    .rsp_data, .rsp_parity_ok, .vpp_high_in, .vpp_high_en, .id_high_voltage, .mem_addr, .chip_sel_n,
    .out_gate_n, .wr_strobe_n, .mem_dq_in, .mem_dq_out, .mem_dq_oe);
  pfc_flash_model #(.MFR(MFR), .DEV(DEV)) i_pfc_flash_model (.cs_n(chip_sel_n), .oe_n(out_gate_n),
    .we_n(wr_strobe_n), .vpp(vpp_high_in), .idv(id_high_voltage), .addr(mem_addr), .din(mem_dq_in), .dout(dq));
  always #50 clk_sys = ~clk_sys;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic acc(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d, e);
    int n = 0;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge clk_sys); while (rsp_valid !== 1'b1 && ++n < 20);
    lat = n;
    compares++;
    if (rsp_valid !== 1'b1 || {rsp_data, rsp_parity_ok} !== {e, ^e}) begin
      n_mismatch++;
      $display("[FAIL] %0t addr %h got %h want %h", $time, a, rsp_data, e);
    end
  endtask
  task automatic results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    acc(OP_HWID, 17'h0, 8'h0, MFR);
    acc(OP_HWID, 17'h1, 8'h0, DEV);
    for (int i = 0; i < 2; i++) begin
      sd = nx(sd);
      acc(OP_WRITE, {1'b0, sd}, i ? CMD_ID : 8'h80, 8'h0);
      acc(OP_READ, ID_MFR_ADDR, 8'h0, MFR);
      acc(OP_WRITE, 17'h0, 8'h55, 8'h0);
      acc(OP_READ, ID_DEV_ADDR, 8'h0, DEV);
      acc(OP_WRITE, 17'h0, i ? CMD_READ : CMD_READ_ALT, 8'h0);
      acc(OP_WRITE, 17'h0, i ? CMD_READ : CMD_READ_ALT, 8'h0);
      sd = nx(sd);
      acc(OP_WRITE, 17'h0, CMD_PROG | {1'b0, i[0], 6'h0}, 8'h0);
      acc(OP_WRITE, {9'h0, sd[15:8]}, sd[7:0], 8'h0);
      acc(OP_READ, {9'h0, sd[15:8]}, 8'h0, sd[7:0]);
    end
    acc(OP_WRITE, 17'h0, CMD_ERASE, 8'h0);
    acc(OP_WRITE, 17'h0, CMD_ERASE, 8'h0);
    acc(OP_READ, {9'h0, sd[15:8]}, 8'h0, 8'hff);
    acc(OP_WRITE, 17'h0, CMD_ID, 8'h0);
    vpp_ok <= 1'b0;
    repeat (10) @(posedge clk_sys);
    acc(OP_WRITE, 17'h0, CMD_PROG, 8'h0);
    compares++;
    if (lat != 0) begin
      n_mismatch++;
      $display("[FAIL] %0t write with low Vpp was not refused", $time);
    end
    vpp_ok <= 1'b1;
    acc(OP_READ, ID_DEV_ADDR, 8'h0, 8'hff);
    results();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    results();
  end
endmodule
